//--- debug_status_register_map.v
// debug status, condition-code holding and register-position bank
`timescale 1ns/1ps
`include "debug_regs_consts.vh"

// How it works
// R1: status register at FF01, reserved FF00, FF02-FF05
// R2: read/write condition-code holding register at FF06
// R3: read-only register position at FF07, FF08-FF0B reserved
// R4: status readable in every mode via debug access
// R5: enable reads one in special single-chip when permitted
// R6: unsecured bit one only if secured and erased
// R7: secure, not erased: unsecured bit hidden from host
// R8: active bit set only by hardware entry
// R9: active bit cleared only by firmware write
// R10: clock select written only by hardware/firmware
// R11: host leaves other status bits alone
// R12: host sets enable only when firmware commands needed
// R13: host accesses through hardware read/write commands only
// R14: entry sets active and maps firmware table
// R15: disabled unit refuses entry, hardware commands still run
// R16: reserved reads fixed, reserved writes have no effect
module debug_status_register_map (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // debug hardware read/write commands from the serial engine
    input wire hw_req,
    input wire hw_wr,
    input wire [15:0] hw_addr,
    input wire [7:0] hw_wdata,
    output reg [7:0] hw_rdata_ff,
    output reg hw_ack_ff,
    // core bus accesses, fw_exec marks code running from the firmware table
    input wire cpu_req,
    input wire cpu_wr,
    input wire [15:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire fw_exec,
    output reg [7:0] cpu_rdata_ff,
    output reg cpu_ack_ff,
    // operating mode and security state
    input wire special_single_chip,
    input wire secured,
    input wire fully_erased,
    // debug hardware events
    input wire enter_req,
    input wire tag_go,
    input wire shift_valid_set,
    input wire shift_valid_clr,
    input wire trace_set,
    input wire trace_clr,
    input wire [15:0] reg_block_base,
    // state towards the rest of the unit
    output wire debug_enable_bit,
    output wire debug_active_bit,
    output wire tagging_enable_bit,
    output wire shift_valid_bit,
    output wire debug_clock_select_bit,
    output wire fw_table_en,
    output wire enter_taken,
    output wire [7:0] cond_code_holding
);

    reg [7:0] status_ff;
    reg [7:0] nxt_status;
    reg [7:0] ccr_ff;
    reg [7:0] nxt_ccr;
    reg permit_q_ff;
    reg [7:0] hw_rd_val;
    reg [7:0] cpu_rd_val;

    wire in_win_hw;
    wire in_win_cpu;
    wire hw_wr_en;
    wire fw_wr_en;
    wire user_wr_en;
    wire hw_st_wr;
    wire fw_st_wr;
    wire fw_ccr_wr;
    wire user_ccr_wr;
    wire hw_ccr_wr;
    wire st_wr;
    wire [7:0] st_wdata;
    wire fw_preset_permit;
    wire preset_enable;
    wire unsecured_status_bit_view;
    wire [7:0] pos_field;
    wire [7:0] status_view;
    wire fw_act_clr;
    wire hw_rsv_hit;
    wire cpu_rsv_hit;

    // the bank only decodes its registers inside its own window
    assign in_win_hw = (hw_addr >= `DBG_WIN_BASE) && (hw_addr <= `DBG_WIN_LAST);
    assign in_win_cpu = (cpu_addr >= `DBG_WIN_BASE) && (cpu_addr <= `DBG_WIN_LAST);

    // reserved holes answer with the fixed pattern and take no write
    assign hw_rsv_hit = (hw_addr == `DBG_RSV0_ADDR) ||
        ((hw_addr >= `DBG_RSV2_ADDR) && (hw_addr <= `DBG_RSV5_ADDR)) ||
        ((hw_addr >= `DBG_RSV8_ADDR) && (hw_addr <= `DBG_RSVB_ADDR)); // R1 R16
    assign cpu_rsv_hit = (cpu_addr == `DBG_RSV0_ADDR) ||
        ((cpu_addr >= `DBG_RSV2_ADDR) && (cpu_addr <= `DBG_RSV5_ADDR)) ||
        ((cpu_addr >= `DBG_RSV8_ADDR) && (cpu_addr <= `DBG_RSVB_ADDR)); // R16

    // hardware commands reach every register in every mode
    assign hw_wr_en = hw_req && hw_wr; // R13
    // the firmware flag splits core stores into firmware and user writers
    assign fw_wr_en = cpu_req && cpu_wr && fw_exec;
    assign user_wr_en = cpu_req && cpu_wr && !fw_exec;

    // status writes come only from hardware commands or firmware stores
    // a user store to status is dropped but still acknowledged
    assign hw_st_wr = hw_wr_en && (hw_addr == `DBG_STATUS_ADDR); // R1
    assign fw_st_wr = fw_wr_en && (cpu_addr == `DBG_STATUS_ADDR); // R1
    // a hardware command wins over a firmware store in the same cycle
    assign st_wr = hw_st_wr || fw_st_wr;
    assign st_wdata = hw_st_wr ? hw_wdata : cpu_wdata;

    // the firmware's own data decides a clear of active; a hardware store
    // that wins the shared data path must not take active down for it
    assign fw_act_clr = fw_st_wr && !cpu_wdata[`ST_ACTIVE_BIT]; // R9

    assign hw_ccr_wr = hw_wr_en && (hw_addr == `DBG_CCR_ADDR); // R2
    assign fw_ccr_wr = fw_wr_en && (cpu_addr == `DBG_CCR_ADDR); // R2
    assign user_ccr_wr = user_wr_en && (cpu_addr == `DBG_CCR_ADDR); // R2

    // the firmware in special single-chip mode sets enable before any
    // command can complete; when secured that waits for the erase check
    // only a rising permit presets, so a later host clear of enable sticks
    assign fw_preset_permit = special_single_chip && (!secured || fully_erased); // R5
    assign preset_enable = fw_preset_permit && !permit_q_ff; // R5

    // entry is refused while enable is clear
    // hardware commands keep being served while entry is refused
    assign enter_taken = enter_req && status_ff[`ST_ENABLE_BIT]; // R15

    // unsecured view: only secured and erased parts in special single-chip
    // report one, so a secured part that is not erased never shows it
    assign unsecured_status_bit_view = special_single_chip && secured && fully_erased; // R6 R7

    // only the position bits the core can move are reported
    assign pos_field = {1'b0, reg_block_base[`POS_MSB:`POS_LSB], 3'b000}; // R3

    // live read view of the status register, bit 0 always reads zero
    // the unsecured bit is not stored, so it follows the security state at once
    assign status_view = {status_ff[7:2], unsecured_status_bit_view, 1'b0}; // R4 R6

    always @*
    begin
        nxt_status = status_ff;
        // enable, tagging, shift-valid and trace are plain data for writers
        if (st_wr)
        begin
            nxt_status[`ST_ENABLE_BIT] = st_wdata[`ST_ENABLE_BIT];
            nxt_status[`ST_TAG_BIT] = st_wdata[`ST_TAG_BIT];
            nxt_status[`ST_SHIFT_VALID_BIT] = st_wdata[`ST_SHIFT_VALID_BIT];
            nxt_status[`ST_TRACE_BIT] = st_wdata[`ST_TRACE_BIT];
            nxt_status[`ST_CLKSEL_BIT] = st_wdata[`ST_CLKSEL_BIT]; // R10
        end
        // only a firmware store can take the active bit down
        if (fw_act_clr)
        begin
            nxt_status[`ST_ACTIVE_BIT] = 1'b0; // R9
        end
        // hardware events override a concurrent write
        if (preset_enable)
        begin
            nxt_status[`ST_ENABLE_BIT] = 1'b1; // R5
        end
        // set beats clear when the engine raises both in one cycle
        if (shift_valid_clr)
        begin
            nxt_status[`ST_SHIFT_VALID_BIT] = 1'b0;
        end
        if (shift_valid_set)
        begin
            nxt_status[`ST_SHIFT_VALID_BIT] = 1'b1;
        end
        // trace follows the same set-over-clear order
        if (trace_clr)
        begin
            nxt_status[`ST_TRACE_BIT] = 1'b0;
        end
        if (trace_set)
        begin
            nxt_status[`ST_TRACE_BIT] = 1'b1;
        end
        if (tag_go)
        begin
            nxt_status[`ST_TAG_BIT] = 1'b1;
        end
        // entry clears tagging and sets active, and wins over a firmware clear
        if (enter_taken)
        begin
            nxt_status[`ST_TAG_BIT] = 1'b0;
            nxt_status[`ST_ACTIVE_BIT] = 1'b1; // R8 R14
        end
        // bits 1 and 0 are not storage
        // so a write can never latch a stale unsecured value
        nxt_status[`ST_UNSECURED_STATUS_BIT_BIT] = 1'b0;
        nxt_status[0] = 1'b0;
    end

    // the core saves its condition codes here; a hardware command wins a
    // same-cycle clash because the host owns the debug session
    always @*
    begin
        nxt_ccr = ccr_ff;
        if (user_ccr_wr || fw_ccr_wr)
        begin
            nxt_ccr = cpu_wdata; // R2
        end
        if (hw_ccr_wr)
        begin
            nxt_ccr = hw_wdata; // R2
        end
    end

    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_ff <= `ST_RESET;
            ccr_ff <= `CCR_RESET;
            // permit history starts low so a part permitted in reset presets at once
            permit_q_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            ccr_ff <= nxt_ccr;
            permit_q_ff <= fw_preset_permit;
        end
    end

    // read multiplexer for hardware commands
    // reserved holes are caught before the case so they read the fixed pattern
    always @*
    begin
        hw_rd_val = `RSV_READ; // R16
        if (in_win_hw && !hw_rsv_hit)
        begin
            case (hw_addr)
                `DBG_STATUS_ADDR: hw_rd_val = status_view; // R4
                `DBG_CCR_ADDR: hw_rd_val = ccr_ff; // R2
                `DBG_REGPOS_ADDR: hw_rd_val = pos_field; // R3
                default: hw_rd_val = `RSV_READ; // R16
            endcase
        end
    end

    // read multiplexer for core bus reads
    // the core sees the same view as the host; security gates neither side
    always @*
    begin
        cpu_rd_val = `RSV_READ; // R16
        if (in_win_cpu && !cpu_rsv_hit)
        begin
            case (cpu_addr)
                `DBG_STATUS_ADDR: cpu_rd_val = status_view;
                `DBG_CCR_ADDR: cpu_rd_val = ccr_ff;
                `DBG_REGPOS_ADDR: cpu_rd_val = pos_field;
                default: cpu_rd_val = `RSV_READ; // R16
            endcase
        end
    end

    // answers are registered so the serial engine sees stable data
    // every request is acked, refused and reserved ones too, so the link never stalls
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hw_rdata_ff <= 8'h00;
            hw_ack_ff <= 1'b0;
            cpu_rdata_ff <= 8'h00;
            cpu_ack_ff <= 1'b0;
        end
        else
        begin
            hw_ack_ff <= hw_req; // R13
            cpu_ack_ff <= cpu_req;
            if (hw_req && !hw_wr)
            begin
                hw_rdata_ff <= hw_rd_val; // R13
            end
            if (cpu_req && !cpu_wr)
            begin
                cpu_rdata_ff <= cpu_rd_val;
            end
        end
    end

    // state outputs come straight from the status flops
    assign debug_enable_bit = status_ff[`ST_ENABLE_BIT];
    assign debug_active_bit = status_ff[`ST_ACTIVE_BIT];
    assign tagging_enable_bit = status_ff[`ST_TAG_BIT];
    assign shift_valid_bit = status_ff[`ST_SHIFT_VALID_BIT];
    assign debug_clock_select_bit = status_ff[`ST_CLKSEL_BIT];
    // the firmware lookup table is in the map exactly while active
    assign fw_table_en = status_ff[`ST_ACTIVE_BIT]; // R14
    assign cond_code_holding = ccr_ff;

endmodule

//--- debug_regs_consts.vh
// constants for the debug status register bank
`ifndef DEBUG_REGS_CONSTS_VH
`define DEBUG_REGS_CONSTS_VH

// debug register window, byte addresses
`define DBG_WIN_BASE 16'hFF00
`define DBG_WIN_LAST 16'hFF0B
`define DBG_RSV0_ADDR 16'hFF00
`define DBG_STATUS_ADDR 16'hFF01
`define DBG_RSV2_ADDR 16'hFF02
`define DBG_RSV5_ADDR 16'hFF05
`define DBG_CCR_ADDR 16'hFF06
`define DBG_REGPOS_ADDR 16'hFF07
`define DBG_RSV8_ADDR 16'hFF08
`define DBG_RSVB_ADDR 16'hFF0B

// debug_status field positions
`define ST_ENABLE_BIT 7
`define ST_ACTIVE_BIT 6
`define ST_TAG_BIT 5
`define ST_SHIFT_VALID_BIT 4
`define ST_TRACE_BIT 3
`define ST_CLKSEL_BIT 2
`define ST_UNSECURED_STATUS_BIT_BIT 1

// reset values
`define ST_RESET 8'h00
`define CCR_RESET 8'h00

// value returned for reserved and unmapped locations
`define RSV_READ 8'h00

// internal_reg_position: bits 6..3 carry block position bits 14..11
`define POS_MSB 14
`define POS_LSB 11
`define POS_FIELD_MSB 6
`define POS_FIELD_LSB 3

`endif

//--- debug_status_register_map_monitor.sv
// checker for the debug status register bank
`timescale 1ns/1ps
module debug_status_register_map_monitor (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // observed ports
    input wire hw_req,
    input wire hw_wr,
    input wire [15:0] hw_addr,
    input wire [7:0] hw_rdata_ff,
    input wire hw_ack_ff,
    input wire cpu_req,
    input wire cpu_wr,
    input wire [15:0] cpu_addr,
    input wire fw_exec,
    input wire special_single_chip,
    input wire secured,
    input wire fully_erased,
    input wire enter_req,
    input wire [15:0] reg_block_base,
    input wire debug_enable_bit,
    input wire debug_active_bit,
    input wire debug_clock_select_bit,
    input wire fw_table_en,
    input wire enter_taken
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire fw_st = cpu_req && cpu_wr && fw_exec && cpu_addr == 16'hFF01;
    wire hw_st = hw_req && hw_wr && hw_addr == 16'hFF01;
    wire permit = special_single_chip && (!secured || fully_erased);
    sequence s_rd(a);
        hw_req && !hw_wr && hw_addr == a;
    endsequence
    AST_HW_ACK: assert property (hw_req |=> hw_ack_ff)
        else $error("missing hw ack");
    AST_ACK_CAUSE: assert property (hw_ack_ff |-> $past(hw_req))
        else $error("hw ack without request");
    AST_POS: assert property (s_rd(16'hFF07) |=>
        hw_rdata_ff == {1'b0, $past(reg_block_base[14:11]), 3'b000}) else $error("bad position");
    AST_UNSECURED_STATUS_BIT: assert property (s_rd(16'hFF01) |=>
        hw_rdata_ff[1:0] == {$past(special_single_chip && secured && fully_erased), 1'b0})
        else $error("bad unsecured bit");
    AST_RSV: assert property (hw_req && !hw_wr && hw_addr inside
        {16'hFF00, [16'hFF02:16'hFF05], [16'hFF08:16'hFF0B]} |=> hw_rdata_ff == 8'h00)
        else $error("reserved read not zero");
    AST_ACT_SET: assert property ($rose(debug_active_bit) |-> $past(enter_taken))
        else $error("active set without entry");
    AST_ACT_CLR: assert property ($fell(debug_active_bit) |-> $past(fw_st))
        else $error("active cleared by other writer");
    AST_ENTRY: assert property (enter_req && debug_enable_bit |=>
        debug_active_bit && fw_table_en) else $error("entry not taken");
    AST_NO_ENTRY: assert property (!debug_enable_bit && !debug_active_bit |=>
        !debug_active_bit) else $error("entry while disabled");
    AST_CLKSEL: assert property ($changed(debug_clock_select_bit) |->
        $past(hw_st || fw_st)) else $error("clock select changed by other writer");
    AST_PRESET: assert property ($rose(permit) |=> debug_enable_bit)
        else $error("enable not preset");
endmodule

//--- host_model.sv
// host debug link model issuing hardware register commands
`timescale 1ns/1ps
module host_model (
    // clock
    input wire sys_clk,
    // hardware command port
    output reg hw_req,
    output reg hw_wr,
    output reg [15:0] hw_addr,
    output reg [7:0] hw_wdata,
    input wire [7:0] hw_rdata_ff,
    input wire hw_ack_ff
);
    initial
    begin
        hw_req = 1'b0;
        hw_wr = 1'b0;
        hw_addr = 16'h0000;
        hw_wdata = 8'h00;
    end
    // one pulsed command per access; released address and data invert so stale values never match
    task access(input w, input [15:0] a, input [7:0] d, output [7:0] q, output ok);
    begin
        @(posedge sys_clk);
        #1;
        hw_req = 1'b1;
        hw_wr = w;
        hw_addr = a;
        hw_wdata = d;
        @(posedge sys_clk);
        #1;
        hw_req = 1'b0;
        hw_addr = ~a;
        hw_wdata = ~d;
        ok = hw_ack_ff;
        q = hw_rdata_ff;
    end
    endtask
endmodule

//--- debug_status_register_map_tb_top.sv
// testbench for the debug status register bank
`timescale 1ns/1ps
module debug_status_register_map_tb_top;
    reg sys_clk = 1'b0;
    reg rstn = 1'b0;
    reg cpu_req = 1'b0, cpu_wr = 1'b0, fw_exec = 1'b0, enter_req = 1'b0;
    reg [15:0] cpu_addr = 16'h0000, reg_block_base = 16'h5800;
    reg [7:0] cpu_wdata = 8'h00, q;
    reg special_single_chip = 1'b1, secured = 1'b0, fully_erased = 1'b0;
    reg tag_go = 1'b0, shift_valid_set = 1'b0, shift_valid_clr = 1'b0;
    reg trace_set = 1'b0, trace_clr = 1'b0, ok;
    wire hw_req, hw_wr, hw_ack_ff, cpu_ack_ff, debug_enable_bit, debug_active_bit;
    wire tagging_enable_bit, shift_valid_bit, debug_clock_select_bit, fw_table_en;
    wire enter_taken;
    wire [15:0] hw_addr;
    wire [7:0] hw_wdata, hw_rdata_ff, cpu_rdata_ff, cond_code_holding;
    integer num_errors = 0, checks = 0, cyc = 0, i;
    always #4 sys_clk = ~sys_clk;
    debug_status_register_map debug_status_register_map_i (.*);
    host_model host_model_i (.*);
    task chk(input [8*6:1] n, input [7:0] got, input [7:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", n, exp, got);
        end
    end
    endtask
    task rd(input [15:0] a, input [7:0] exp, input [8*6:1] n);
    begin
        host_model_i.access(1'b0, a, 8'h00, q, ok);
        chk("ack", {7'h00, ok}, 8'h01);
        chk(n, q, exp);
    end
    endtask
    task wr(input [15:0] a, input [7:0] d);
    begin
        host_model_i.access(1'b1, a, d, q, ok);
        chk("ack", {7'h00, ok}, 8'h01);
    end
    endtask
    task cw(input [15:0] a, input [7:0] d, input fw);
    begin
        @(posedge sys_clk);
        #1;
        cpu_req = 1'b1;
        cpu_wr = 1'b1;
        cpu_addr = a;
        cpu_wdata = d;
        fw_exec = fw;
        @(posedge sys_clk);
        #1;
        cpu_req = 1'b0;
        fw_exec = 1'b0;
    end
    endtask
    task cr(input [15:0] a, input [7:0] exp, input [8*6:1] n);
    begin
        @(posedge sys_clk);
        #1;
        cpu_req = 1'b1;
        cpu_wr = 1'b0;
        cpu_addr = a;
        @(posedge sys_clk);
        #1;
        cpu_req = 1'b0;
        chk("cack", {7'h00, cpu_ack_ff}, 8'h01);
        chk(n, cpu_rdata_ff, exp);
    end
    endtask
    task ev(input tg, input svs, input svc, input trs, input trc);
    begin
        @(posedge sys_clk);
        #1;
        tag_go = tg;
        shift_valid_set = svs;
        shift_valid_clr = svc;
        trace_set = trs;
        trace_clr = trc;
        @(posedge sys_clk);
        #1;
        tag_go = 1'b0;
        shift_valid_set = 1'b0;
        shift_valid_clr = 1'b0;
        trace_set = 1'b0;
        trace_clr = 1'b0;
    end
    endtask
    task pulse_entry;
    begin
        @(posedge sys_clk);
        #1;
        enter_req = 1'b1;
        @(posedge sys_clk);
        #1;
        enter_req = 1'b0;
    end
    endtask
    task results;
    begin
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            num_errors = num_errors + 1;
            results;
        end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        rd(16'hFF01, 8'h80, "status");
        wr(16'hFF06, 8'hA5);
        rd(16'hFF06, 8'hA5, "ccr");
        wr(16'hFF07, 8'hFF);
        rd(16'hFF07, 8'h58, "regpos");
        for (i = 0; i < 12; i = i + 1)
            if (i != 1 && i != 6 && i != 7)
            begin
                wr(16'hFF00 + i[15:0], 8'hFF);
                rd(16'hFF00 + i[15:0], 8'h00, "rsvd");
            end
        rd(16'hFF06, 8'hA5, "ccr");
        wr(16'hFF01, 8'hC4);
        rd(16'hFF01, 8'h84, "status");
        cw(16'hFF01, 8'h80, 1'b0);
        rd(16'hFF01, 8'h84, "status");
        pulse_entry;
        rd(16'hFF01, 8'hC4, "status");
        chk("fwtab", {7'h00, fw_table_en}, 8'h01);
        ev(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        rd(16'hFF01, 8'hFC, "status");
        chk("tagen", {6'h00, tagging_enable_bit, shift_valid_bit}, 8'h03);
        pulse_entry;
        rd(16'hFF01, 8'hDC, "status");
        ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        chk("clksel", {7'h00, debug_clock_select_bit}, 8'h01);
        fork
            cw(16'hFF01, 8'hC4, 1'b1);
            wr(16'hFF01, 8'h84);
        join
        rd(16'hFF01, 8'hC4, "status");
        cw(16'hFF01, 8'h80, 1'b1);
        rd(16'hFF01, 8'h80, "status");
        secured = 1'b1;
        fully_erased = 1'b1;
        rd(16'hFF01, 8'h82, "status");
        fully_erased = 1'b0;
        rd(16'hFF01, 8'h80, "status");
        wr(16'hFF01, 8'h00);
        pulse_entry;
        rd(16'hFF01, 8'h00, "status");
        fully_erased = 1'b1;
        rd(16'hFF01, 8'h82, "status");
        cw(16'hFF06, 8'h3C, 1'b0);
        cr(16'hFF06, 8'h3C, "ccr");
        chk("ccrout", cond_code_holding, 8'h3C);
        cr(16'hFF01, 8'h82, "status");
        results;
    end
endmodule
bind debug_status_register_map debug_status_register_map_monitor
    debug_status_register_map_monitor_i (.*);
